/* File: src/dtsl_pkg.sv */
// Purpose: constants for the debug trigger and run-status block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes: all offsets are byte addresses
package dtsl_pkg;

    // ========================================
    // register map
    localparam logic [7:0] DTSL_OFF_CTRL = 8'h00;
    localparam logic [7:0] DTSL_OFF_TRIG = 8'h04;
    localparam logic [7:0] DTSL_OFF_STAT = 8'h08;

    // ========================================
    // debug_control_reg fields
    localparam int DTSL_CTRL_EN_BIT = 7;
    localparam int DTSL_CTRL_ARM_BIT = 6;
    localparam int DTSL_CTRL_BRK_BIT = 4;

    // ========================================
    // debug_trigger_config fields
    localparam int DTSL_TRIG_QUAL_BIT = 7;
    localparam int DTSL_TRIG_BEGIN_BIT = 6;
    localparam logic [7:0] DTSL_TRIG_WMASK = 8'hCF;
    localparam logic [7:0] DTSL_TRIG_RESET = 8'h00;

    // ========================================
    // debug_run_status fields
    localparam int DTSL_STAT_AF_BIT = 7;
    localparam int DTSL_STAT_BF_BIT = 6;
    localparam int DTSL_STAT_RUN_ACTIVE_FLAG_BIT = 5;

    localparam int DTSL_FIFO_DEPTH = 8;
    localparam int DTSL_CNT_W = 4;

    localparam logic [1:0] DTSL_RESP_OKAY = 2'h0;
    localparam logic [1:0] DTSL_RESP_SLVERR = 2'h2;

    // ========================================
    // trigger mode codes
    typedef enum logic [3:0] {
        DTSL_M_A_ONLY = 4'b0000,
        DTSL_M_A_OR_B = 4'b0001,
        DTSL_M_A_THEN_B = 4'b0010,
        DTSL_M_EV_B = 4'b0011,
        DTSL_M_A_THEN_EV_B = 4'b0100,
        DTSL_M_A_AND_DB = 4'b0101,
        DTSL_M_A_AND_NDB = 4'b0110,
        DTSL_M_INSIDE = 4'b0111,
        DTSL_M_OUTSIDE = 4'b1000
    } dtsl_mode_e;

endpackage

/* File: src/dtsl_core.sv */
// Purpose: trigger-mode selection and run-status reporting of a bus-analysis debug unit
// Assumes: comparator, opcode tracking and change-of-flow inputs are synchronous to clk
// Notes: FIFO storage itself lives outside; this block issues store strobes
//
// What this block does
// [R01] trigger config readable; writable only when disarmed
// [R02] config bits 4 and 5 read zero
// [R03] qualify bit gates matches by opcode execution
// [R04] begin bit chooses begin or end trace
// [R05] event-only modes always behave as begin trace
// [R06] modes 0000 A, 0001 A or B, 0010 A-then-B
// [R07] 0011 stores on B; 0100 after A first
// [R08] 0101 A and data B; 0110 A and not
// [R09] 0111 inside range; 1000 outside range
// [R10] codes 1001 to 1111 never trigger
// [R11] run status is read-only
// [R12] A flag cleared at start, set on match
// [R13] B flag cleared at start, set on match
// [R14] run-active mirrors arm while unit enabled
// [R15] run ends on full (begin) or trigger (end)
// [R16] writing zero to arm or enable stops run
// [R17] valid count cleared at start, up to eight
// [R18] valid count does not drop on FIFO reads
// [R19] host tracks remaining words itself while reading
// [R20] break request at run end when enabled
// [R21] unit enable cannot be set while secured
// [R22] match flags hold until next run start
//
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns

module dtsl_core
    import dtsl_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int FIFO_DEPTH = DTSL_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite slave
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // device context
    input wire logic secure_mode,
    // comparator and tracking inputs, one bus cycle each
    input wire logic bus_access,
    input wire logic addr_match_a,
    input wire logic addr_match_b,
    input wire logic data_match_b,
    input wire logic addr_below_a,
    input wire logic addr_above_b,
    input wire logic exec_at_a,
    input wire logic exec_at_b,
    input wire logic exec_fetch,
    input wire logic cof_event,
    // toward FIFO and CPU
    output logic fifo_store,
    output logic fifo_clear,
    output logic halt_request,
    output logic run_active
);

    initial begin
        if (FIFO_DEPTH < 1 || FIFO_DEPTH > 15) begin
            $error("FIFO_DEPTH must be 1..15 for a 4-bit count");
        end
        if (ADDR_W < 4) begin
            $error("ADDR_W must reach the status register");
        end
    end

    localparam logic [DTSL_CNT_W-1:0] DEPTH_C = DTSL_CNT_W'(FIFO_DEPTH);

    // ========================================
    // state
    typedef struct packed {
        logic en;
        logic arm;
        logic brk_en;
        logic [7:0] cfg;
        logic af;
        logic bf;
        logic [DTSL_CNT_W-1:0] cnt;
        logic a_seen;
        logic trig_seen;
        logic store;
        logic clr;
        logic brk;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
    } dtsl_state_s;

    dtsl_state_s s_q;
    dtsl_state_s s_d;

    logic qual;
    logic begin_eff;
    logic event_mode;
    logic hit_a;
    logic hit_b;
    logic in_range;
    logic range_hit;
    logic out_hit;
    logic trig;
    logic run_end;
    logic wr_fire;
    logic rd_fire;
    logic [7:0] waddr;
    logic [7:0] raddr;
    logic [7:0] stat_img;
    dtsl_mode_e mode;

    // address and data are taken together; a lone channel waits for its partner
    assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_q.bvalid;
    assign s_axi_wready = s_axi_awready;
    assign s_axi_arready = ~s_q.rvalid;
    assign wr_fire = s_axi_awready;
    assign rd_fire = s_axi_arvalid & ~s_q.rvalid;
    assign waddr = 8'(s_axi_awaddr);
    assign raddr = 8'(s_axi_araddr);

    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rresp = s_q.rresp;
    assign s_axi_rdata = s_q.rdata;

    assign fifo_store = s_q.store;
    assign fifo_clear = s_q.clr;
    assign halt_request = s_q.brk;
    assign run_active = s_q.arm & s_q.en; // see [R14]

    // ========================================
    // match qualification and trigger decode
    assign qual = s_q.cfg[DTSL_TRIG_QUAL_BIT];
    assign mode = dtsl_mode_e'(s_q.cfg[3:0]);
    // force type takes the raw access, tag type waits for execution
    assign hit_a = qual ? exec_at_a : addr_match_a; // see [R03]
    assign hit_b = qual ? exec_at_b : addr_match_b; // see [R03]
    assign in_range = ~addr_below_a & ~addr_above_b;
    assign range_hit = in_range & (qual ? exec_fetch : bus_access); // see [R09]
    assign out_hit = ~in_range & (qual ? exec_fetch : bus_access); // see [R09]
    assign event_mode = (mode == DTSL_M_EV_B) || (mode == DTSL_M_A_THEN_EV_B);
    // event-only runs are always begin traces
    assign begin_eff = s_q.cfg[DTSL_TRIG_BEGIN_BIT] | event_mode; // see [R04] [R05]

    always_comb begin
        trig = 1'b0;
        unique case (s_q.cfg[3:0])
            DTSL_M_A_ONLY: trig = hit_a; // see [R06]
            DTSL_M_A_OR_B: trig = hit_a | hit_b; // see [R06]
            DTSL_M_A_THEN_B: trig = s_q.a_seen & hit_b; // see [R06]
            DTSL_M_EV_B: trig = 1'b0; // see [R07]
            DTSL_M_A_THEN_EV_B: trig = 1'b0; // see [R07]
            DTSL_M_A_AND_DB: trig = hit_a & data_match_b; // see [R08]
            DTSL_M_A_AND_NDB: trig = hit_a & ~data_match_b; // see [R08]
            DTSL_M_INSIDE: trig = range_hit; // see [R09]
            DTSL_M_OUTSIDE: trig = out_hit; // see [R09]
            default: trig = 1'b0; // see [R10]
        endcase
    end

    // begin trace ends on a full FIFO, end trace on its trigger
    assign run_end = s_q.arm & (begin_eff ? (s_q.cnt == DEPTH_C) : trig); // see [R15]

    assign stat_img = {s_q.af, s_q.bf, s_q.arm & s_q.en, 1'b0, s_q.cnt};

    // ========================================
    // next state
    always_comb begin
        s_d = s_q;
        s_d.store = 1'b0;
        s_d.clr = 1'b0;
        s_d.brk = 1'b0;

        // flags are only ever set here, so they hold once the run is over
        if (s_q.arm) begin // see [R22]
            if (hit_a) begin
                s_d.af = 1'b1; // see [R12]
                s_d.a_seen = 1'b1;
            end
            if (hit_b) begin
                s_d.bf = 1'b1; // see [R13]
            end
            if (trig) begin
                s_d.trig_seen = 1'b1;
            end
            if (event_mode) begin
                if (mode == DTSL_M_EV_B) begin
                    s_d.store = hit_b; // see [R07]
                end else begin
                    s_d.store = s_q.a_seen & hit_b; // see [R07]
                end
            end else if (begin_eff) begin
                s_d.store = (s_q.trig_seen | trig) & cof_event; // see [R04]
            end else begin
                s_d.store = cof_event; // see [R04]
            end
            // a full begin trace stores nothing more
            if (begin_eff && s_q.cnt == DEPTH_C) begin
                s_d.store = 1'b0;
            end
            if (s_d.store && s_q.cnt != DEPTH_C) begin
                s_d.cnt = s_q.cnt + 1'b1; // see [R17]
            end
            if (run_end) begin
                s_d.arm = 1'b0; // see [R15]
                s_d.store = 1'b0;
                s_d.brk = s_q.brk_en; // see [R20]
            end
        end

        // register writes
        if (wr_fire) begin
            s_d.bvalid = 1'b1;
            s_d.bresp = DTSL_RESP_OKAY;
            if (waddr == DTSL_OFF_CTRL) begin
                if (s_axi_wstrb[0]) begin
                    // enable may always be cleared, never set when secured
                    s_d.en = s_axi_wdata[DTSL_CTRL_EN_BIT] & ~secure_mode; // see [R21]
                    s_d.brk_en = s_axi_wdata[DTSL_CTRL_BRK_BIT];
                    if (!s_axi_wdata[DTSL_CTRL_ARM_BIT] || !s_d.en) begin
                        s_d.arm = 1'b0; // see [R16]
                        s_d.store = 1'b0;
                    end else if (!s_q.arm) begin
                        s_d.arm = 1'b1; // see [R14]
                        s_d.clr = 1'b1;
                        s_d.af = 1'b0; // see [R12]
                        s_d.bf = 1'b0; // see [R13]
                        s_d.cnt = '0; // see [R17]
                        s_d.a_seen = 1'b0;
                        s_d.trig_seen = 1'b0;
                    end
                end
            end else if (waddr == DTSL_OFF_TRIG) begin
                if (s_axi_wstrb[0] && !s_q.arm) begin
                    s_d.cfg = s_axi_wdata[7:0] & DTSL_TRIG_WMASK; // see [R01] [R02]
                end
            end else if (waddr == DTSL_OFF_STAT) begin
                s_d.bresp = DTSL_RESP_OKAY; // see [R11]
            end else begin
                s_d.bresp = DTSL_RESP_SLVERR;
            end
        end else if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        // register reads have no side effect on the count
        if (rd_fire) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = DTSL_RESP_OKAY;
            s_d.rdata = '0;
            if (raddr == DTSL_OFF_CTRL) begin
                s_d.rdata[DTSL_CTRL_EN_BIT] = s_q.en;
                s_d.rdata[DTSL_CTRL_ARM_BIT] = s_q.arm;
                s_d.rdata[DTSL_CTRL_BRK_BIT] = s_q.brk_en;
            end else if (raddr == DTSL_OFF_TRIG) begin
                s_d.rdata[7:0] = s_q.cfg; // see [R01]
            end else if (raddr == DTSL_OFF_STAT) begin
                s_d.rdata[7:0] = stat_img; // see [R18]
            end else begin
                s_d.rresp = DTSL_RESP_SLVERR;
            end
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.cfg <= DTSL_TRIG_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // ========================================
    // checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic cfg_wr;
    logic ctrl_wr;
    assign cfg_wr = wr_fire && waddr == DTSL_OFF_TRIG && s_axi_wstrb[0];
    assign ctrl_wr = wr_fire && waddr == DTSL_OFF_CTRL;

    a_cfg_locked: assert property ( // see [R01]
        s_q.arm && cfg_wr |=> $stable(s_q.cfg))
        else $error("trigger config changed while armed");

    a_cfg_takes: assert property ( // see [R01]
        !s_q.arm && cfg_wr |=> s_q.cfg == ($past(s_axi_wdata[7:0]) & DTSL_TRIG_WMASK))
        else $error("trigger config write lost while disarmed");

    a_cfg_reserved: assert property ( // see [R02]
        s_q.cfg[5:4] == 2'b00)
        else $error("reserved config bits not zero");

    a_high_modes: assert property ( // see [R10]
        s_q.cfg[3:0] > 4'h8 |-> !trig)
        else $error("unused mode produced a trigger");

    a_end_trig: assert property ( // see [R15]
        s_q.arm && !begin_eff && trig |=> !s_q.arm)
        else $error("end trace kept running after trigger");

    a_end_full: assert property ( // see [R15]
        s_q.arm && begin_eff && s_q.cnt == DEPTH_C |=> !s_q.arm)
        else $error("begin trace kept running when full");

    a_start_clears: assert property ( // see [R12] [R13] [R17]
        s_q.clr |-> !s_q.af && !s_q.bf && s_q.cnt == '0 && s_q.arm)
        else $error("run start left stale status");

    a_af_set: assert property ( // see [R12]
        s_q.arm && hit_a |=> s_q.af)
        else $error("comparator A match not flagged");

    a_bf_set: assert property ( // see [R13]
        s_q.arm && hit_b |=> s_q.bf)
        else $error("comparator B match not flagged");

    a_flags_hold: assert property ( // see [R22]
        !s_q.arm && !(ctrl_wr && s_axi_wdata[DTSL_CTRL_ARM_BIT])
        |=> $stable(s_q.af) && $stable(s_q.bf))
        else $error("match flags changed outside a run");

    a_cnt_hold: assert property ( // see [R18]
        !s_q.arm && !s_d.clr |=> $stable(s_q.cnt))
        else $error("valid count moved while idle");

    a_cnt_max: assert property ( // see [R17]
        s_q.cnt <= DEPTH_C)
        else $error("valid count beyond depth");

    a_stop_write: assert property ( // see [R16]
        ctrl_wr && s_axi_wstrb[0] && !s_axi_wdata[DTSL_CTRL_ARM_BIT] |=> !run_active)
        else $error("run not stopped by arm write of zero");

    a_secure_en: assert property ( // see [R21]
        secure_mode && !s_q.en |=> !s_q.en)
        else $error("unit enabled while secured");

    a_break_src: assert property ( // see [R20]
        s_q.brk |-> $past(s_q.brk_en) && $past(s_q.arm) && !s_q.arm)
        else $error("halt request without run end");

    // a stop write in the same cycle may legally drop the store
    a_event_store: assert property ( // see [R07]
        s_q.arm && mode == DTSL_M_EV_B && hit_b && s_q.cnt < DEPTH_C && !run_end
        && !ctrl_wr |=> fifo_store)
        else $error("event-only B store missed");

endmodule // dtsl_core

/* File: test/dtsl_partner_model.sv */
// Purpose: stands in for the bus comparators and tracking logic
// Assumes: each request drives one pattern for exactly one clock
// Notes: lines drop to zero between requests, as comparator outputs do
`timescale 1ns/1ns

module dtsl_partner_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic req,
    input wire logic [9:0] pat,
    output logic [9:0] lines
);
    // a match is a one-cycle event; holding it would fake extra hits
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lines <= 10'h000;
        end else begin
            lines <= req ? pat : 10'h000;
        end
    end
endmodule // dtsl_partner_model

/* File: test/test_debug_trigger_status_logic.sv */
// Purpose: self-checking bench for the debug trigger and status block
// Assumes: pattern bits 9..0 = bus, A, B, data B, below A, above B, exec A/B/fetch, cof
// Notes: random config values use a fixed seed
`timescale 1ns/1ns

module test_debug_trigger_status_logic;
    import dtsl_pkg::*;
    logic clk, rst, awv, wv, bready, arv, rready, secure, req;
    logic awready, wready, bvalid, arready, rvalid;
    logic fifo_store, fifo_clear, halt_request, run_active;
    logic [7:0] awaddr, araddr, v;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [9:0] pat, lines;
    int err_count, n_compared, n_store, n_halt, n_clear, h0, s0;
    int unsigned seed_v;
    logic [7:0] t_cfg [20] = '{8'h00, 8'h01, 8'h02, 8'h02, 8'h05, 8'h05, 8'h06, 8'h06,
        8'h07, 8'h07, 8'h08, 8'h08, 8'h09, 8'h0C, 8'h0F, 8'h80, 8'h80, 8'h87, 8'h87, 8'h81};
    logic [9:0] t_p1 [20] = '{10'h100, 10'h080, 10'h100, 10'h080, 10'h140, 10'h100, 10'h100,
        10'h140, 10'h200, 10'h210, 10'h220, 10'h200, 10'h3FE, 10'h3FE, 10'h3FE, 10'h100,
        10'h108, 10'h202, 10'h200, 10'h084};
    logic [9:0] t_p2 [20] = '{10'h000, 10'h000, 10'h080, 10'h000, 10'h000, 10'h000, 10'h000,
        10'h000, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000, 10'h3FE, 10'h000, 10'h000,
        10'h000, 10'h000, 10'h000, 10'h000};
    // bit i set: run i ends on its own trigger
    logic [19:0] t_end = 20'hB0557;

    dtsl_partner_model far_side (.clk(clk), .rst(rst), .req(req), .pat(pat), .lines(lines));

    dtsl_core uut (.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wv),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .secure_mode(secure),
        .bus_access(lines[9]), .addr_match_a(lines[8]), .addr_match_b(lines[7]),
        .data_match_b(lines[6]), .addr_below_a(lines[5]), .addr_above_b(lines[4]),
        .exec_at_a(lines[3]), .exec_at_b(lines[2]), .exec_fetch(lines[1]),
        .cof_event(lines[0]), .fifo_store(fifo_store), .fifo_clear(fifo_clear),
        .halt_request(halt_request), .run_active(run_active));

    // ========================================
    // pulse counters and shared tasks
    always @(posedge clk) begin
        n_store += (fifo_store === 1'b1);
        n_halt += (halt_request === 1'b1);
        n_clear += (fifo_clear === 1'b1);
    end

    task automatic conclude();
        if (err_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic bump(inout int n);
        n++;
        if (n > 200) begin
            err_count++;
            conclude();
        end
    endtask

    function automatic logic [7:0] stat(input logic af, input logic bf, input logic [3:0] c);
        return {af, bf, 2'b00, c};
    endfunction

    // with the qualify bit set the flags follow the executed-opcode lines
    function automatic logic [7:0] exp_stat(input logic [7:0] c, input logic [9:0] p,
        input logic act);
        return {c[7] ? p[3] : p[8], c[7] ? p[2] : p[7], act, 5'h00};
    endfunction

    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        logic aw_ok;
        logic w_ok;
        n = 0;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        // each channel is released at the edge that takes it
        while (!(aw_ok && w_ok)) begin
            bump(n);
            @(negedge clk);
            aw_ok = aw_ok || awready === 1'b1;
            w_ok = w_ok || wready === 1'b1;
            @(posedge clk);
            if (aw_ok) begin
                awv <= 1'b0;
            end
            if (w_ok) begin
                wv <= 1'b0;
            end
        end
        @(negedge clk);
        while (bvalid !== 1'b1) begin
            bump(n);
            @(negedge clk);
        end
        check("bresp", {30'h0, bresp}, {30'h0, er});
        @(posedge clk);
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        @(negedge clk);
        while (arready !== 1'b1) begin
            bump(n);
            @(negedge clk);
        end
        @(posedge clk);
        arv <= 1'b0;
        @(negedge clk);
        while (rvalid !== 1'b1) begin
            bump(n);
            @(negedge clk);
        end
        check("rdata", rdata, {24'h0, d});
        check("rresp", {30'h0, rresp}, {30'h0, er});
        @(posedge clk);
        rready <= 1'b0;
    endtask

    task automatic hit(input logic [9:0] p);
        @(posedge clk);
        pat <= p;
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ========================================
    // main sequence
    initial begin
        {rst, awv, wv, bready, arv, rready, secure, req} = 8'h80;
        {awaddr, araddr, wdata, pat} = '0;
        wstrb = 4'hF;
        seed_v = $urandom(32'hCC57);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        axi_rd(DTSL_OFF_TRIG, DTSL_TRIG_RESET, DTSL_RESP_OKAY);
        axi_rd(8'h0C, 8'h00, DTSL_RESP_SLVERR);
        axi_wr(8'h10, 8'hFF, DTSL_RESP_SLVERR);
        axi_wr(DTSL_OFF_STAT, 8'hFF, DTSL_RESP_OKAY);
        axi_rd(DTSL_OFF_STAT, 8'h00, DTSL_RESP_OKAY);
        for (int i = 0; i < 6; i++) begin
            v = 8'($urandom());
            axi_wr(DTSL_OFF_TRIG, v, DTSL_RESP_OKAY);
            axi_rd(DTSL_OFF_TRIG, v & DTSL_TRIG_WMASK, DTSL_RESP_OKAY);
        end
        for (int i = 0; i < 20; i++) begin
            axi_wr(DTSL_OFF_TRIG, t_cfg[i], DTSL_RESP_OKAY);
            axi_wr(DTSL_OFF_CTRL, 8'hD0, DTSL_RESP_OKAY);
            h0 = n_halt;
            hit(t_p1[i]);
            hit(t_p2[i]);
            check("active", 32'(run_active), 32'(!t_end[i]));
            check("halt", n_halt, h0 + t_end[i]);
            v = exp_stat(t_cfg[i], t_p1[i] | t_p2[i], !t_end[i]);
            axi_rd(DTSL_OFF_STAT, v, DTSL_RESP_OKAY);
            if (!t_end[i]) begin
                axi_wr(DTSL_OFF_TRIG, 8'h00, DTSL_RESP_OKAY);
                axi_rd(DTSL_OFF_TRIG, t_cfg[i], DTSL_RESP_OKAY);
                axi_wr(DTSL_OFF_CTRL, (i % 2) ? 8'h40 : 8'h00, DTSL_RESP_OKAY);
                check("stopped", {31'h0, run_active}, 32'h0);
            end
        end
        axi_wr(DTSL_OFF_TRIG, 8'h40, DTSL_RESP_OKAY);
        axi_wr(DTSL_OFF_CTRL, 8'hD0, DTSL_RESP_OKAY);
        {h0, s0} = {n_halt, n_store};
        hit(10'h001);
        hit(10'h001);
        check("pre_store", n_store, s0);
        hit(10'h101);
        repeat (7) hit(10'h001);
        check("stores", n_store, s0 + 8);
        check("halt", n_halt, h0 + 1);
        axi_rd(DTSL_OFF_STAT, stat(1'b1, 1'b0, 4'h8), DTSL_RESP_OKAY);
        axi_rd(DTSL_OFF_STAT, stat(1'b1, 1'b0, 4'h8), DTSL_RESP_OKAY);
        for (int m = 3; m < 5; m++) begin
            axi_wr(DTSL_OFF_TRIG, 8'(m), DTSL_RESP_OKAY);
            axi_wr(DTSL_OFF_CTRL, 8'hD0, DTSL_RESP_OKAY);
            s0 = n_store;
            if (m == 4) begin
                hit(10'h080);
                check("early_b", n_store, s0);
                hit(10'h100);
            end
            repeat (8) hit(10'h080);
            check("events", n_store, s0 + 8);
            axi_rd(DTSL_OFF_STAT, stat(m == 4, 1'b1, 4'h8), DTSL_RESP_OKAY);
        end
        h0 = n_clear;
        axi_wr(DTSL_OFF_TRIG, 8'h09, DTSL_RESP_OKAY);
        axi_wr(DTSL_OFF_CTRL, 8'hC0, DTSL_RESP_OKAY);
        axi_rd(DTSL_OFF_STAT, 8'h20, DTSL_RESP_OKAY);
        check("clear", n_clear, h0 + 1);
        axi_wr(DTSL_OFF_CTRL, 8'h00, DTSL_RESP_OKAY);
        secure <= 1'b1;
        axi_wr(DTSL_OFF_CTRL, 8'hC0, DTSL_RESP_OKAY);
        axi_rd(DTSL_OFF_CTRL, 8'h00, DTSL_RESP_OKAY);
        check("secured", {31'h0, run_active}, 32'h0);
        conclude();
    end
endmodule // test_debug_trigger_status_logic
